// ### design/ucp_cell_port.sv
// UTOPIA cell port top: cell-level handshake, receive-first arbitration,
// PHY addressing, pacing tick count and receive connection lookup.
// Assumes the PHY holds whole cells and bursts them without gaps.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Cell data moves eight bits per transfer in each direction.
// RQ2 - Flow control is a single handshake per whole cell.
// RQ3 - No cell FIFO here; the PHY stores the cell and sends it as one burst.
// RQ4 - A two-bit PHY address is driven so four PHYs can share the port.
// RQ5 - External logic decodes the address to route handshakes to one PHY.
// RQ6 - Receive is served before transmit within a shared cell bandwidth.
// RQ7 - Faster links need an outside FIFO keeping average load under 70 Mbps.
// RQ8 - Serial cell transport needs a byte-boundary indication with the stream.
// RQ9 - Framed serial sources supply frame sync and byte-aligned cells.
// RQ10 - Transmit pacing counts ticks from the dedicated timer four.
// RQ11 - Up to 32 connections are held internally, more go external.
// RQ12 - Internal and external connection entries may be used together.
// RQ13 - Lookup may use an external content-addressable memory instead.
// RQ14 - Cells of 53 bytes and expanded cells up to 64 bytes are handled.
// RQ15 - Cell data moves to memory buffers through burst DMA transfers.
// RQ16 - The Ethernet channel is disabled while the cell port is in use.
// RQ17 - Port signals sit on parallel port D; serial signals move to A and C.
module ucp_cell_port
  import ucp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Port control, PHY select and pin muxing
  input wire logic port_enable_in,
  input wire logic [6:0] cell_len_in,
  input wire logic [1:0] rx_phy_in,
  input wire logic [1:0] tx_phy_in,
  output logic [UCP_ADDR_W-1:0] phy_addr_out,
  output logic port_d_utopia_sel_out,
  output logic serial_on_ac_out,
  output logic eth_disable_out,
  // Receive cell side toward the PHY
  input wire logic rx_cell_avail_in,
  output logic rx_enable_out,
  input wire logic [UCP_DATA_W-1:0] rx_data_in,
  input wire logic rx_soc_in,
  // Transmit cell side toward the PHY
  output logic tx_cell_avail_n_out,
  input wire logic tx_cell_space_in,
  output logic tx_enable_out,
  output logic [UCP_DATA_W-1:0] tx_data_out,
  output logic tx_soc_out,
  // Burst DMA streams on the memory side
  input wire logic dma_tx_valid_in,
  input wire ucp_pkg::ucp_byte_t dma_tx_data_in,
  output logic dma_tx_ready_out,
  output logic dma_rx_valid_out,
  output ucp_pkg::ucp_byte_t dma_rx_data_out,
  input wire logic dma_rx_ready_in,
  // Pacing timer tick and its count
  input wire logic pace_tick_in,
  output logic [15:0] pace_count_out,
  // Serial cell stream with byte sync
  input wire logic serial_byte_sync_in,
  input wire logic serial_bit_valid_in,
  input wire logic serial_bit_in,
  output logic serial_byte_valid_out,
  output logic [7:0] serial_byte_out,
  // Connection table load and lookup
  input wire logic tbl_wr_in,
  input wire logic [4:0] tbl_idx_in,
  input wire logic [UCP_VC_W-1:0] tbl_vc_in,
  input wire logic ext_hit_in,
  input wire logic [4:0] ext_idx_in,
  output logic [UCP_VC_W-1:0] lookup_key_out,
  output ucp_pkg::ucp_lookup_t lookup_out
);
  import ucp_pkg::*;


  // Arbiter and burst state
  ucp_state_t state_q;
  logic [6:0] cnt_q;
  logic [6:0] len_q;
  logic [1:0] phy_q;

  // Header key and pacing count
  logic [UCP_VC_W-1:0] key_q;
  logic [15:0] pace_q;

  // Serial byte assembly
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic aligned_q;
  logic ser_valid_q;
  logic [7:0] ser_byte_q;

  // Stream buffer handshakes
  logic rx_buf_ready;
  logic rx_push;
  ucp_byte_t rx_word;
  logic tx_buf_valid;
  ucp_byte_t tx_buf_word;
  logic tx_pop;
  logic tx_data_ready;

  // Registered transmit pins
  logic [7:0] tx_data_q;
  logic tx_soc_q;
  logic tx_en_q;

  // End of the current burst
  logic last_byte;


  // Clamp cell length between standard and expanded size.
  // A short length would cut a header in half, and a
  // long one would run past the tag bytes, so both are
  // pulled back to the nearest legal size.
  function automatic logic [6:0] clamp_len(input logic [6:0] len);
    if (len < UCP_STD_CELL_BYTES) return UCP_STD_CELL_BYTES;
    if (len > UCP_MAX_CELL_BYTES) return UCP_MAX_CELL_BYTES;
    return len;
  endfunction : clamp_len


  // Static pin muxing while the port is enabled.
  // The Ethernet channel shares these pins, so it is
  // held off for as long as the cell port owns them.
  // Purely combinational: no cycle of double ownership.
  assign port_d_utopia_sel_out = port_enable_in; // [RQ17]
  assign serial_on_ac_out = port_enable_in; // [RQ17]
  assign eth_disable_out = port_enable_in; // [RQ16]
  assign phy_addr_out = phy_q; // [RQ4]
  assign last_byte = (cnt_q == len_q - 7'd1);


  // Cell handshake arbiter: receive checked first, one grant per cell.
  // Receive wins because the PHY cannot hold many cells;
  // transmit only loses bandwidth, never data.
  // Grants are taken in idle only, so a burst is never
  // split between the two directions.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= UCP_IDLE;
      phy_q <= UCP_PHY_RST;
      len_q <= UCP_STD_CELL_BYTES;
    end else begin
      unique case (state_q)
        UCP_IDLE: begin
          if (port_enable_in && rx_cell_avail_in) begin // [RQ6] [RQ2]
            state_q <= UCP_RX;
            phy_q <= rx_phy_in; // [RQ4]
            len_q <= clamp_len(cell_len_in); // [RQ14]
          end else if (port_enable_in && tx_cell_space_in && tx_buf_valid
                       && tx_buf_word.sop) begin
            state_q <= UCP_TX;
            phy_q <= tx_phy_in;
            len_q <= clamp_len(cell_len_in); // [RQ14]
          end
        end
        UCP_RX: begin
          if (rx_push && last_byte) state_q <= UCP_IDLE; // [RQ3]
        end
        UCP_TX: begin
          if (tx_pop && last_byte) state_q <= UCP_IDLE; // [RQ3]
        end
      endcase
    end
  end


  // Byte counter inside the current cell burst.
  // Cleared in idle so every grant starts at byte zero;
  // it advances only on a moved byte, so stalls are safe.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= UCP_CNT_RST;
    end else if (state_q == UCP_IDLE) begin
      cnt_q <= UCP_CNT_RST;
    end else if (rx_push || tx_pop) begin
      cnt_q <= cnt_q + 7'd1;
    end
  end


  // Receive path: enable stays low if the buffer fills so no byte is lost.
  // The PHY holds its byte while enable is low, so a
  // slow memory side costs time but never a byte.
  assign rx_enable_out = (state_q == UCP_RX) && rx_buf_ready; // [RQ2]
  assign rx_push = rx_enable_out;
  assign rx_word.data = rx_data_in; // [RQ1]
  assign rx_word.sop = (cnt_q == UCP_CNT_RST) || rx_soc_in;
  assign rx_word.eop = last_byte;


  // Receive buffer: two entries absorb one cycle of
  // DMA stall without a combinational path from the
  // memory side back to the PHY enable.
  ucp_skid_buf u_rx_buf (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(rx_push),
    .in_data_in(rx_word),
    .in_ready_out(rx_buf_ready),
    .out_valid_out(dma_rx_valid_out), // [RQ15]
    .out_data_out(dma_rx_data_out),
    .out_ready_in(dma_rx_ready_in)
  );


  // Transmit path from burst DMA into the two-entry buffer.
  // The DMA side may pause at will; the grant waits
  // until a start-of-cell byte sits at the head.
  ucp_skid_buf u_tx_buf (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(dma_tx_valid_in),
    .in_data_in(dma_tx_data_in),
    .in_ready_out(dma_tx_ready_out), // [RQ15]
    .out_valid_out(tx_buf_valid),
    .out_data_out(tx_buf_word),
    .out_ready_in(tx_data_ready)
  );


  // Pop only while granted; the available flag is low
  // when a start-of-cell byte waits at the buffer head,
  // so the PHY sees a cell offer only at cell start.
  assign tx_data_ready = (state_q == UCP_TX);
  assign tx_pop = tx_data_ready && tx_buf_valid;
  assign tx_cell_avail_n_out = ~(tx_buf_valid && tx_buf_word.sop);


  // Transmit pins registered; a DMA underrun simply idles the enable.
  // Limitation: an underrun leaves a gap inside the
  // burst, which a strict PHY may not accept.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_data_q <= '0;
      tx_soc_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= tx_pop;
      tx_soc_q <= tx_pop && (cnt_q == UCP_CNT_RST);
      if (tx_pop) tx_data_q <= tx_buf_word.data; // [RQ1]
    end
  end
  assign tx_enable_out = tx_en_q;
  assign tx_data_out = tx_data_q;
  assign tx_soc_out = tx_soc_q;


  // Header key capture: bytes 0..2 hold the connection identifier.
  // The key is kept after the cell so an external
  // lookup may answer late without a second copy.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_q <= '0;
    end else if (rx_push && cnt_q < 7'd3) begin
      key_q <= {key_q[UCP_VC_W-9:0], rx_data_in};
    end
  end
  assign lookup_key_out = key_q; // [RQ13]


  // Connection table: internal entries first, external
  // answer only when no internal entry matches, so the
  // busiest circuits never pay the slower path.
  ucp_conn_table u_table (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(tbl_wr_in), // [RQ11]
    .wr_idx_in(tbl_idx_in),
    .wr_vc_in(tbl_vc_in),
    .key_in(key_q),
    .ext_hit_in(ext_hit_in), // [RQ12] [RQ13]
    .ext_idx_in(ext_idx_in),
    .result_out(lookup_out)
  );


  // Pacing tick counter; tick rate sets pacing granularity.
  // Sixteen bits wrap silently; the scheduler works on
  // differences, so a wrap does no harm.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) pace_q <= UCP_PACE_RST;
    else if (pace_tick_in) pace_q <= pace_q + 16'h0001; // [RQ10]
  end
  assign pace_count_out = pace_q;


  // Serial byte assembly: nothing is delivered until a byte sync is seen.
  // A sync restarts the count on its own bit, so a
  // late sync realigns without a flush.
  // Bits without a valid strobe are ignored.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aligned_q <= 1'b0;
      bit_cnt_q <= 3'd0;
      shift_q <= UCP_ALIGN_RST;
      ser_valid_q <= 1'b0;
      ser_byte_q <= UCP_ALIGN_RST;
    end else begin
      ser_valid_q <= 1'b0;
      if (serial_bit_valid_in) begin
        shift_q <= {shift_q[6:0], serial_bit_in};
        if (serial_byte_sync_in) begin // [RQ8] [RQ9]
          aligned_q <= 1'b1;
          bit_cnt_q <= 3'd1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 3'd1;
          if (aligned_q && bit_cnt_q == 3'd7) begin // [RQ8]
            ser_valid_q <= 1'b1;
            ser_byte_q <= {shift_q[6:0], serial_bit_in};
          end
        end
      end
    end
  end

  // Byte and its strobe come straight from flip-flops
  assign serial_byte_valid_out = ser_valid_q;
  assign serial_byte_out = ser_byte_q;
endmodule : ucp_cell_port

// ### design/ucp_conn_table.sv
// Receive connection table: 32 internal entries, overflow to external lookup.
// Assumes the external lookup (compressed table or CAM) answers on ext_*.
`timescale 1ns/1ps
module ucp_conn_table
  import ucp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [4:0] wr_idx_in,
  input wire logic [UCP_VC_W-1:0] wr_vc_in,
  input wire logic [UCP_VC_W-1:0] key_in,
  input wire logic ext_hit_in,
  input wire logic [4:0] ext_idx_in,
  output ucp_pkg::ucp_lookup_t result_out
);
  logic [UCP_VC_W-1:0] vc_q [UCP_INT_CONN];
  logic [UCP_INT_CONN-1:0] used_q;
  logic [UCP_INT_CONN-1:0] match;
  ucp_lookup_t res_d;

  // Entry writes; one per generate slot
  genvar g;
  generate
    for (g = 0; g < UCP_INT_CONN; g++) begin : g_ent
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          vc_q[g] <= '0;
          used_q[g] <= 1'b0;
        end else if (wr_en_in && (wr_idx_in == 5'(g))) begin
          vc_q[g] <= wr_vc_in;
          used_q[g] <= 1'b1;
        end
      end
      assign match[g] = used_q[g] && (vc_q[g] == key_in);
    end
  endgenerate

  // Internal hits win so busy connections avoid the slower external path
  always_comb begin
    res_d = '0;
    for (int i = UCP_INT_CONN - 1; i >= 0; i--) begin
      if (match[i]) begin
        res_d.hit = 1'b1;
        res_d.internal = 1'b1;
        res_d.index = 5'(i);
      end
    end
    if (!res_d.hit && ext_hit_in) begin
      res_d.hit = 1'b1;
      res_d.index = ext_idx_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) result_out <= '0;
    else result_out <= res_d;
  end
endmodule : ucp_conn_table

// ### design/ucp_pkg.sv
// Package for the UTOPIA cell port: widths, cell sizes, modes and carriers.
// Assumes one 20 MHz clock domain and no software-reachable registers.
package ucp_pkg;
  localparam int unsigned UCP_DATA_W = 8;
  localparam int unsigned UCP_ADDR_W = 2;
  localparam int unsigned UCP_NUM_PHY = 4;
  localparam logic [6:0] UCP_STD_CELL_BYTES = 7'd53;
  localparam logic [6:0] UCP_MAX_CELL_BYTES = 7'd64;
  localparam int unsigned UCP_INT_CONN = 32;
  localparam int unsigned UCP_VC_W = 24;
  localparam int unsigned UCP_BUF_DEPTH = 2;
  localparam logic [15:0] UCP_PACE_RST = 16'h0000;
  localparam logic [6:0] UCP_CNT_RST = 7'h00;
  localparam logic [1:0] UCP_PHY_RST = 2'h0;
  localparam logic [7:0] UCP_ALIGN_RST = 8'h00;

  // One byte of a cell with its framing marks
  typedef struct packed {
    logic [UCP_DATA_W-1:0] data;
    logic sop;
    logic eop;
  } ucp_byte_t;

  // Lookup result for a received cell header
  typedef struct packed {
    logic hit;
    logic internal;
    logic [4:0] index;
  } ucp_lookup_t;

  // Port state machine, one-hot
  typedef enum logic [2:0] {
    UCP_IDLE = 3'b001,
    UCP_RX = 3'b010,
    UCP_TX = 3'b100
  } ucp_state_t;
endpackage : ucp_pkg

// ### design/ucp_skid_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
module ucp_skid_buf
  import ucp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  input wire ucp_pkg::ucp_byte_t in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output ucp_pkg::ucp_byte_t out_data_out,
  input wire logic out_ready_in
);
  ucp_byte_t mem_q [UCP_BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Handshakes are combinational; storage is registered
  assign in_ready_out = (count_q != 2'd2);
  assign out_valid_out = (count_q != 2'd0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage writes
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : ucp_skid_buf

// ### tb/testbench.sv
// Bench for the cell port: PHY model on the cell side, bench on the DMA side.
// Assumes a 20 MHz clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module testbench;
  import ucp_pkg::*;
  logic clk = 0, rst = 1, en = 0, go = 0, rxr = 1, txs = 0, tv = 0, tick = 0;
  logic sv = 0, sb = 0, sy = 0, tw = 0, eh = 0;
  logic [6:0] len = 7'h35;
  logic [1:0] rp = 2'h0, tp = 2'h0, pa;
  logic [7:0] base = 8'h00, rd, txd, sbyte;
  logic [4:0] ti = 5'h00, ei = 5'h00;
  logic [23:0] tvc = 24'h00_0000, key;
  ucp_byte_t td = '0, rdd;
  ucp_lookup_t lk;
  logic av, busy, soc, rxe, txe, txso, rdv, tdr, sbv, ps, sac, ethd, tan;
  int bad_count = 0, comparisons = 0;

  always #25 clk = ~clk;

  ucp_cell_port i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .port_enable_in(en),
    .cell_len_in(len), .rx_phy_in(rp), .tx_phy_in(tp), .phy_addr_out(pa),
    .port_d_utopia_sel_out(ps), .serial_on_ac_out(sac), .eth_disable_out(ethd),
    .rx_cell_avail_in(av), .rx_enable_out(rxe), .rx_data_in(rd), .rx_soc_in(soc),
    .tx_cell_avail_n_out(tan), .tx_cell_space_in(txs), .tx_enable_out(txe),
    .tx_data_out(txd), .tx_soc_out(txso), .dma_tx_valid_in(tv), .dma_tx_data_in(td),
    .dma_tx_ready_out(tdr), .dma_rx_valid_out(rdv), .dma_rx_data_out(rdd),
    .dma_rx_ready_in(rxr), .pace_tick_in(tick), .pace_count_out(),
    .serial_byte_sync_in(sy), .serial_bit_valid_in(sv), .serial_bit_in(sb),
    .serial_byte_valid_out(sbv), .serial_byte_out(sbyte), .tbl_wr_in(tw),
    .tbl_idx_in(ti), .tbl_vc_in(tvc), .ext_hit_in(eh), .ext_idx_in(ei),
    .lookup_key_out(key), .lookup_out(lk));

  ucp_phy_model i_phy (.ref_clk_in(clk), .sys_rst_in(rst), .go_in(go), .len_in(len),
    .base_in(base), .rx_enable_in(rxe), .avail_out(av), .busy_out(busy),
    .data_out(rd), .soc_out(soc));

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // A wait that ran out ends the run at once
  task automatic tmo(input bit hit);
    if (hit) begin
      check("timeout", 0, 1);
      report_and_stop();
    end
  endtask : tmo

  // Pull one cell from the PHY; optional DMA stall fills the buffer mid-cell
  task automatic rx_cell(input logic [6:0] n_in, input logic [1:0] p_in,
                         input logic [7:0] b_in, input bit stall);
    int n;
    int k;
    n = 0;
    @(posedge clk);
    len <= n_in;
    rp <= p_in;
    base <= b_in;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 500 && n < n_in; k++) begin
      @(negedge clk);
      if (rdv && rxr) begin
        check("rx byte", {22'h0, b_in + n[7:0], n == 0, n == n_in - 1}, rdd);
        n++;
      end
      @(posedge clk);
      rxr <= !stall || k[0];
    end
    @(posedge clk);
    rxr <= 1'b1;
    tmo(n < n_in);
    check("rx phy", p_in, pa);
  endtask : rx_cell

  // Send one cell; with rx_too a receive cell competes at the same moment
  task automatic tx_cell(input logic [6:0] n_in, input bit rx_too);
    int i;
    int m;
    int k;
    i = 0;
    m = 0;
    @(posedge clk);
    len <= n_in;
    tp <= 2'h2;
    txs <= 1'b1;
    go <= rx_too;
    tv <= 1'b1;
    td <= {8'h80, 1'b1, 1'b0};
    for (k = 0; k < 900 && m < n_in; k++) begin
      @(negedge clk);
      if (txe) begin
        check("tx byte", {23'h0, 8'h80 + m[7:0], m == 0}, {txd, txso});
        check("rx first", 0, busy);
        m++;
      end
      i = i + (tv && tdr);
      @(posedge clk);
      go <= 1'b0;
      tv <= i < n_in;
      td <= {8'h80 + i[7:0], i == 0, i == n_in - 1};
    end
    tmo(m < n_in);
    check("tx phy", 2, pa);
    check("tx avail n", 1, tan);
  endtask : tx_cell

  // Back-to-back ticks, a gap, then one more
  task automatic pace_run;
    int k;
    for (k = 0; k < 7; k++) begin
      @(posedge clk);
      tick <= k != 4 && k < 6;
    end
    @(negedge clk);
    check("pace", 5, i_dut.pace_count_out);
  endtask : pace_run

  // Eight bits without sync must yield nothing; a palindrome hides bit order
  task automatic serial_run;
    int k;
    int hits;
    logic [7:0] ptn;
    hits = 0;
    ptn = 8'hA5;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      sv <= k < 16;
      sy <= k == 8;
      sb <= ptn[k[2:0]];
      @(negedge clk);
      if (sbv) begin
        hits++;
        check("ser byte", 8'hA5, sbyte);
      end
    end
    check("ser count", 1, hits);
  endtask : serial_run

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("mux off", 3'b000, {ps, sac, ethd});
    @(posedge clk);
    en <= 1'b1;
    @(negedge clk);
    check("mux on", 3'b111, {ps, sac, ethd});
    pace_run();
    serial_run();
    @(posedge clk);
    tw <= 1'b1;
    ti <= 5'h05;
    tvc <= 24'h10_1112;
    eh <= 1'b1;
    ei <= 5'h09;
    @(posedge clk);
    tw <= 1'b0;
    rx_cell(7'h35, 2'h1, 8'h10, 1'b0);
    check("key", 24'h10_1112, key);
    check("int hit", 7'h65, lk);
    rx_cell(7'h40, 2'h3, 8'h40, 1'b1);
    check("ext hit", 7'h49, lk);
    tx_cell(7'h35, 1'b1);
    tx_cell(7'h40, 1'b0);
    report_and_stop();
  end
endmodule : testbench

bind ucp_cell_port ucp_cell_port_props i_props (.ref_clk_in, .sys_rst_in, .port_enable_in,
  .rx_phy_in, .phy_addr_out, .port_d_utopia_sel_out, .serial_on_ac_out, .eth_disable_out,
  .rx_enable_out, .tx_enable_out, .tx_soc_out, .pace_tick_in, .pace_count_out,
  .serial_byte_valid_out);

// ### tb/ucp_cell_port_props.sv
// Checker for the cell port top: port muxing, direction exclusion, pacing, serial bytes.
// Assumes one clock domain; bound from the bench top onto the design top.
`timescale 1ns/1ps
module ucp_cell_port_props (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic port_enable_in,
  input wire logic [1:0] rx_phy_in,
  input wire logic [1:0] phy_addr_out,
  input wire logic port_d_utopia_sel_out,
  input wire logic serial_on_ac_out,
  input wire logic eth_disable_out,
  input wire logic rx_enable_out,
  input wire logic tx_enable_out,
  input wire logic tx_soc_out,
  input wire logic pace_tick_in,
  input wire logic [15:0] pace_count_out,
  input wire logic serial_byte_valid_out
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_eth_off: assert property (eth_disable_out == port_enable_in)
    else $error("ethernet disable does not follow port enable");
  a_port_mux: assert property (port_d_utopia_sel_out == port_enable_in)
    else $error("port mux select does not follow port enable");
  a_serial_moved: assert property (serial_on_ac_out == port_enable_in)
    else $error("serial relocation does not follow port enable");
  a_one_direction: assert property (!(rx_enable_out && tx_enable_out))
    else $error("receive and transmit active together");
  a_grant_addr: assert property ($rose(rx_enable_out) |-> phy_addr_out == $past(rx_phy_in))
    else $error("phy address differs from requested receive phy");
  a_tick_counts: assert property (pace_tick_in |=> pace_count_out == $past(pace_count_out) + 16'h0001)
    else $error("pace tick not counted");
  a_tick_idle: assert property (!pace_tick_in |=> $stable(pace_count_out))
    else $error("pace count moved without a tick");
  a_soc_framed: assert property (tx_soc_out |-> tx_enable_out)
    else $error("start of cell outside a transmit byte");
  a_byte_spacing: assert property (serial_byte_valid_out |=> !serial_byte_valid_out [*7])
    else $error("serial bytes closer than eight bits");

  // Main traffic seen at least once
  c_rx_burst: cover property ($rose(rx_enable_out));
  c_tx_cell: cover property (tx_soc_out);
  c_serial_byte: cover property (serial_byte_valid_out);
endmodule : ucp_cell_port_props

// ### tb/ucp_phy_model.sv
// PHY partner: holds one receive cell whole and bursts it when the port pulls.
// Assumes the bench raises go_in only while the port is idle.
`timescale 1ns/1ps
module ucp_phy_model (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic go_in,
  input wire logic [6:0] len_in,
  input wire logic [7:0] base_in,
  input wire logic rx_enable_in,
  output logic avail_out,
  output logic busy_out,
  output logic [7:0] data_out,
  output logic soc_out
);
  logic [6:0] idx_q;
  // One cell per go keeps the average load far below the port's capacity
  // Cell stays in PHY storage until pulled; one handshake per cell, no byte gaps
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avail_out <= 1'b0;
      busy_out <= 1'b0;
      idx_q <= 7'h00;
    end else if (go_in) begin
      avail_out <= 1'b1;
      busy_out <= 1'b1;
      idx_q <= 7'h00;
    end else if (rx_enable_in && busy_out) begin
      avail_out <= 1'b0;
      idx_q <= idx_q + 7'h01;
      if (idx_q + 7'h01 == len_in) begin
        busy_out <= 1'b0;
      end
    end
  end
  // Outside a cell the data lines show the inverse, so stale bytes never match
  assign data_out = busy_out ? base_in + {1'b0, idx_q} : ~(base_in + {1'b0, idx_q});
  assign soc_out = busy_out && idx_q == 7'h00;
endmodule : ucp_phy_model
